// ---- pkg/port_map_pkg.sv ----
/*
  Shared constants and carrier types for the core port and memory map adapter.
  Assumes one 200 MHz clock domain; the core, its special function register block
  and the extension register set all run on that same clock.
*/
package port_map_pkg;

    // Clock and pin drive timing
    localparam int CLK_PERIOD_PS         = 5000;
    localparam int XTAL_PERIOD_PS_DEF    = 100000;
    localparam int STRONG_HI_XTAL_CYCLES = 2;

    // Port widths and pin counts
    localparam int PORT_W       = 8;
    localparam int KEY_SCAN_W   = 16;
    localparam int P3_PIN_CNT   = 4;
    localparam int NUM_PINS     = KEY_SCAN_W + P3_PIN_CNT;

    // Port 3 bit positions of the serial lines
    localparam int MOUSE_DATA_BIT = 0;
    localparam int MOUSE_CLK_BIT  = 1;
    localparam int KBD_CLK_BIT    = 4;
    localparam int KBD_DATA_BIT   = 5;

    // Reset values
    localparam logic [7:0] LATCH_RESET    = 8'hff;
    localparam logic [7:0] READ_ZERO      = 8'h00;

    // External data window and internal memory map
    localparam logic [15:0] XREG_FIRST_ADDR  = 16'h0000;
    localparam logic [15:0] XREG_LAST_ADDR   = 16'h002f;
    localparam int          XREG_ADDR_W      = 6;
    localparam logic [7:0]  IRAM_DIRECT_LAST = 8'h7f;
    localparam logic [7:0]  SFR_FIRST        = 8'h80;
    localparam int          IRAM_DEPTH       = 256;
    localparam int          IRAM_ADDR_W      = 8;

    // One pseudo open-drain pin: strong drive, level, weak keeper
    typedef struct packed {
        logic o;
        logic oe;
        logic weak_hi;
    } pin_drive_t;

    // External data move request from the core
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } xd_req_t;

    // Access towards the extension register set
    typedef struct packed {
        logic                   re;
        logic                   we;
        logic [XREG_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
    } xreg_req_t;

    // Internal data access from the core
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       indirect;
        logic [7:0] addr;
        logic [7:0] wdata;
    } idata_req_t;

    // Access towards the special function register block
    typedef struct packed {
        logic       re;
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // Core functions held off in this device
    typedef struct packed {
        logic strobe_pins_off;
        logic serial_port_off;
        logic second_timer_off;
        logic port0_reserved;
    } core_strap_t;

    localparam core_strap_t STRAP_RESET = '{1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// ---- logic/iram_mem.sv ----
/*
  Internal data RAM of the core, single port, registered read data.
  Assumes read and write requests never arrive in the same cycle.
*/
`timescale 1ns/1ps

module iram_mem #(
    parameter int DEPTH  = 256,
    parameter int ADDR_W = 8,
    parameter int WIDTH  = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              we,
    input  wire logic              re,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [WIDTH-1:0]  wdata,
    output logic      [WIDTH-1:0]  rdata
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // Storage
    always_ff @(posedge clk) begin
        if (we) begin
            mem_reg[addr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= mem_reg[addr];
        end
    end

endmodule

// ---- logic/mcu_port_and_memory_map.sv ----
/*
  Glue between the embedded core and the keyboard/mouse pins: port mapping,
  pseudo open-drain pin drive, external data window and internal data map.
  Assumes the core, its special function registers and the extension
  registers share clk; only the reset pin and the serial lines are asynchronous.
*/
`timescale 1ns/1ps

// What this block does
// [RL1] Reset pin active high holds core reset
// [RL2] Key scan 0-7 from port 1 latch
// [RL3] Key scan 8-15 from port 2 latch
// [RL4] Mouse data P3.0, clock P3.1, bidirectional
// [RL5] Keyboard clock P3.4, data P3.5
// [RL6] Low sinks; rise drives strong two crystal cycles
// [RL7] Bus strobe pin functions disabled
// [RL8] External data goes to extension registers only
// [RL9] Extension registers at 00h to 2Fh
// [RL10] Port 0, P3.2/3/6/7 not general I/O
// [RL11] External interrupts from internal sources only
// [RL12] Serial port and second timer omitted
// [RL13] 256 bytes of internal data RAM
// [RL14] RAM 00h-7Fh direct and indirect
// [RL15] RAM 80h-FFh indirect only
// [RL16] Direct 80h-FFh selects special function registers
// [RL17] Port 1/2 reads return output latch
// [RL18] External data above 2Fh reads zero
module mcu_port_and_memory_map
    import port_map_pkg::*;
#(
    parameter int XTAL_PERIOD_PS = XTAL_PERIOD_PS_DEF
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     reset_pin,
    output logic                          core_reset,
    output core_strap_t                   core_strap,
    input  wire logic [PORT_W-1:0]        p1_latch,
    input  wire logic [PORT_W-1:0]        p2_latch,
    input  wire logic [PORT_W-1:0]        p3_latch,
    output logic      [PORT_W-1:0]        p1_read,
    output logic      [PORT_W-1:0]        p2_read,
    output logic      [PORT_W-1:0]        p3_read,
    output pin_drive_t [KEY_SCAN_W-1:0]   key_scan_out,
    input  wire logic                     mouse_line_data_in,
    output pin_drive_t                    mouse_line_data,
    input  wire logic                     mouse_line_clock_in,
    output pin_drive_t                    mouse_line_clock,
    input  wire logic                     kbd_line_clock_in,
    output pin_drive_t                    kbd_line_clock,
    input  wire logic                     kbd_line_data_in,
    output pin_drive_t                    kbd_line_data,
    input  wire logic [1:0]               special_irq_src,
    output logic                          ext_irq_a,
    output logic                          ext_irq_b,
    input  wire xd_req_t                  xd_req,
    output logic                          xd_rvalid,
    output logic      [7:0]               xd_rdata,
    output xreg_req_t                     extension_regs,
    input  wire logic [7:0]               xreg_rdata,
    input  wire idata_req_t               idata_req,
    output logic                          idata_rvalid,
    output logic      [7:0]               idata_rdata,
    output sfr_req_t                      special_func_regs,
    input  wire logic [7:0]               sfr_rdata
);

    localparam int STRONG_HI_PS  = STRONG_HI_XTAL_CYCLES * XTAL_PERIOD_PS;
    localparam int STRONG_HI_CNT = (STRONG_HI_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BOOST_W       = $clog2(STRONG_HI_CNT + 1);
    localparam logic [BOOST_W-1:0] BOOST_LOAD = BOOST_W'(STRONG_HI_CNT);

    // Reset pin and serial line synchronisers
    logic [1:0]            rst_pin_sync_reg;
    logic                  core_reset_reg;
    logic [P3_PIN_CNT-1:0] line_meta_reg;
    logic [P3_PIN_CNT-1:0] line_sync_reg;
    core_strap_t           strap_reg;

    wire [P3_PIN_CNT-1:0] line_in = {kbd_line_data_in, kbd_line_clock_in,
                                     mouse_line_clock_in, mouse_line_data_in};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pin_sync_reg <= 2'h3;
            core_reset_reg   <= 1'b1;
            line_meta_reg    <= '1;
            line_sync_reg    <= '1;
            strap_reg        <= STRAP_RESET;
        end else begin
            rst_pin_sync_reg <= {rst_pin_sync_reg[0], reset_pin};
            core_reset_reg   <= rst_pin_sync_reg[1]; // [RL1]
            line_meta_reg    <= line_in;
            line_sync_reg    <= line_meta_reg;
            // Straps are constant: those core functions stay off
            strap_reg        <= STRAP_RESET; // [RL7] [RL10] [RL12]
        end
    end

    assign core_reset = core_reset_reg;
    assign core_strap = strap_reg;

    // Latches seen by the pins; released high while the core is in reset
    wire [PORT_W-1:0] p1_eff = core_reset_reg ? LATCH_RESET : p1_latch;
    wire [PORT_W-1:0] p2_eff = core_reset_reg ? LATCH_RESET : p2_latch;
    wire [PORT_W-1:0] p3_eff = core_reset_reg ? LATCH_RESET : p3_latch;

    // Only these port 3 bits reach pins; port 0 reaches none
    wire [P3_PIN_CNT-1:0] p3_pin_level = {p3_eff[KBD_DATA_BIT], p3_eff[KBD_CLK_BIT],
                                          p3_eff[MOUSE_CLK_BIT],
                                          p3_eff[MOUSE_DATA_BIT]}; // [RL4] [RL5] [RL10]
    wire [NUM_PINS-1:0]   drive_level  = {p3_pin_level, p2_eff, p1_eff}; // [RL2] [RL3]

    // Port read back
    logic [PORT_W-1:0] p1_read_reg;
    logic [PORT_W-1:0] p2_read_reg;
    logic [PORT_W-1:0] p3_read_reg;

    // Serial bits read the pins, reserved bits the latch
    wire [PORT_W-1:0] p3_read_next;
    assign p3_read_next[MOUSE_DATA_BIT] = line_sync_reg[0]; // [RL4]
    assign p3_read_next[MOUSE_CLK_BIT]  = line_sync_reg[1]; // [RL4]
    assign p3_read_next[2]              = p3_latch[2]; // [RL10]
    assign p3_read_next[3]              = p3_latch[3]; // [RL10]
    assign p3_read_next[KBD_CLK_BIT]    = line_sync_reg[2]; // [RL5]
    assign p3_read_next[KBD_DATA_BIT]   = line_sync_reg[3]; // [RL5]
    assign p3_read_next[6]              = p3_latch[6]; // [RL10]
    assign p3_read_next[7]              = p3_latch[7]; // [RL10]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p1_read_reg <= LATCH_RESET;
            p2_read_reg <= LATCH_RESET;
            p3_read_reg <= LATCH_RESET;
        end else begin
            p1_read_reg <= p1_latch; // [RL17]
            p2_read_reg <= p2_latch; // [RL17]
            p3_read_reg <= p3_read_next;
        end
    end

    assign p1_read = p1_read_reg;
    assign p2_read = p2_read_reg;
    assign p3_read = p3_read_reg;

    // Pseudo open-drain drivers, one per pin
    pin_drive_t [NUM_PINS-1:0] drive_all;

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        logic               level_reg;
        logic [BOOST_W-1:0] boost_reg;
        pin_drive_t         drive_reg;

        wire                want_hi    = drive_level[i];
        wire                rising     = want_hi & ~level_reg;
        wire                boost_busy = boost_reg != '0;
        // Strong high countdown; a new rise reloads it
        wire [BOOST_W-1:0]  boost_dec  = boost_reg - 1'b1;
        wire [BOOST_W-1:0]  boost_next = !want_hi   ? '0 :
                                         rising     ? BOOST_LOAD :
                                         boost_busy ? boost_dec : '0; // [RL6]

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                level_reg <= 1'b1;
                boost_reg <= '0;
                drive_reg.o       <= 1'b1;
                drive_reg.oe      <= 1'b0;
                drive_reg.weak_hi <= 1'b1;
            end else begin
                level_reg         <= want_hi;
                boost_reg         <= boost_next;
                drive_reg.o       <= want_hi;
                drive_reg.oe      <= ~want_hi | (boost_next != '0); // [RL6]
                drive_reg.weak_hi <= want_hi; // [RL6]
            end
        end

        assign drive_all[i] = drive_reg;
    end

    assign key_scan_out     = drive_all[KEY_SCAN_W-1:0]; // [RL2] [RL3]
    assign mouse_line_data  = drive_all[KEY_SCAN_W];
    assign mouse_line_clock = drive_all[KEY_SCAN_W+1];
    assign kbd_line_clock   = drive_all[KEY_SCAN_W+2];
    assign kbd_line_data    = drive_all[KEY_SCAN_W+3];

    // Interrupt inputs of the core
    logic irq_a_reg;
    logic irq_b_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_a_reg <= 1'b1;
            irq_b_reg <= 1'b1;
        end else begin
            irq_a_reg <= special_irq_src[0]; // [RL11]
            irq_b_reg <= special_irq_src[1]; // [RL11]
        end
    end

    assign ext_irq_a = irq_a_reg;
    assign ext_irq_b = irq_b_reg;

    // External data moves
    xreg_req_t xreg_reg;
    logic      xd_pend_reg;
    logic      xd_hit_reg;
    logic      xd_rvalid_reg;
    logic [7:0] xd_rdata_reg;

    // Full 16-bit compare, so no alias above the window
    wire xd_in_window = (xd_req.addr >= XREG_FIRST_ADDR) &
                        (xd_req.addr <= XREG_LAST_ADDR); // [RL9]

    wire xd_rd        = xd_req.valid & ~xd_req.write;
    wire xd_wr        = xd_req.valid & xd_req.write;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xreg_reg      <= '0;
            xd_pend_reg   <= 1'b0;
            xd_hit_reg    <= 1'b0;
            xd_rvalid_reg <= 1'b0;
            xd_rdata_reg  <= READ_ZERO;
        end else begin
            xreg_reg.re    <= xd_rd & xd_in_window; // [RL8]
            xreg_reg.we    <= xd_wr & xd_in_window; // [RL8] [RL18]
            xreg_reg.addr  <= xd_req.addr[XREG_ADDR_W-1:0];
            xreg_reg.wdata <= xd_req.wdata;
            xd_pend_reg    <= xd_rd;
            xd_hit_reg     <= xd_in_window;
            xd_rvalid_reg  <= xd_pend_reg;
            // Read data hold until the next read
            if (xd_pend_reg) begin
                xd_rdata_reg <= xd_hit_reg ? xreg_rdata : READ_ZERO; // [RL18]
            end
        end
    end

    assign extension_regs = xreg_reg;
    assign xd_rvalid      = xd_rvalid_reg;
    assign xd_rdata       = xd_rdata_reg;

    // Internal data: RAM or special function registers
    sfr_req_t   sfr_reg;
    logic       id_pend_reg;
    logic       id_ram_reg;
    logic       id_rvalid_reg;
    logic [7:0] id_rdata_reg;
    logic [7:0] ram_rdata;

    // Indirect reaches all RAM; direct upper half the registers
    wire id_ram_sel = idata_req.indirect |
                      (idata_req.addr <= IRAM_DIRECT_LAST); // [RL14] [RL15]
    wire id_sfr_sel = ~idata_req.indirect &
                      (idata_req.addr >= SFR_FIRST); // [RL16]

    wire id_rd      = idata_req.valid & ~idata_req.write;
    wire id_wr      = idata_req.valid & idata_req.write;

    iram_mem #(
        .DEPTH  (IRAM_DEPTH),
        .ADDR_W (IRAM_ADDR_W),
        .WIDTH  (8)
    ) u_iram (
        .clk    (clk),
        .rst_n  (rst_n),
        .we     (id_wr & id_ram_sel),
        .re     (id_rd & id_ram_sel),
        .addr   (idata_req.addr),
        .wdata  (idata_req.wdata),
        .rdata  (ram_rdata)
    ); // [RL13]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_reg       <= '0;
            id_pend_reg   <= 1'b0;
            id_ram_reg    <= 1'b0;
            id_rvalid_reg <= 1'b0;
            id_rdata_reg  <= READ_ZERO;
        end else begin
            sfr_reg.re    <= id_rd & id_sfr_sel; // [RL16]
            sfr_reg.we    <= id_wr & id_sfr_sel; // [RL16]
            sfr_reg.addr  <= idata_req.addr;
            sfr_reg.wdata <= idata_req.wdata;
            id_pend_reg   <= id_rd;
            id_ram_reg    <= id_ram_sel;
            id_rvalid_reg <= id_pend_reg;
            // Read data hold until the next read
            if (id_pend_reg) begin
                id_rdata_reg <= id_ram_reg ? ram_rdata : sfr_rdata; // [RL15]
            end
        end
    end

    assign special_func_regs = sfr_reg;
    assign idata_rvalid      = id_rvalid_reg;
    assign idata_rdata       = id_rdata_reg;

endmodule

// ---- test/port_map_asserts.sv ----
/*
  Concurrent checks on the port and memory map adapter.
  Assumes a bind to the top module's ports; one clock domain.
*/
`timescale 1ns/1ps

module port_map_asserts
    import port_map_pkg::*;
#(
    parameter int XTAL_PERIOD_PS = XTAL_PERIOD_PS_DEF
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   reset_pin,
    input  wire logic                   core_reset,
    input  wire core_strap_t            core_strap,
    input  wire logic [PORT_W-1:0]      p1_latch,
    input  wire logic [PORT_W-1:0]      p2_latch,
    input  wire logic [PORT_W-1:0]      p1_read,
    input  wire pin_drive_t [KEY_SCAN_W-1:0] key_scan_out,
    input  wire pin_drive_t             mouse_line_clock,
    input  wire logic [1:0]             special_irq_src,
    input  wire logic                   ext_irq_a,
    input  wire logic                   ext_irq_b,
    input  wire xd_req_t                xd_req,
    input  wire logic                   xd_rvalid,
    input  wire logic [7:0]             xd_rdata,
    input  wire xreg_req_t              extension_regs,
    input  wire idata_req_t             idata_req,
    input  wire logic                   idata_rvalid,
    input  wire sfr_req_t               special_func_regs
);
    localparam int STRONG_N = (2 * XTAL_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    logic [15:0] ks_o;
    logic [7:0]  hi_cnt_reg;

    always_comb begin
        for (int i = 0; i < KEY_SCAN_W; i++) begin
            ks_o[i] = key_scan_out[i].o;
        end
    end

    // Cycles of strong high drive on the mouse clock line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt_reg <= 8'h00;
        end else begin
            hi_cnt_reg <= (mouse_line_clock.o && mouse_line_clock.oe) ? hi_cnt_reg + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence xd_rd_s;
        xd_req.valid && !xd_req.write;
    endsequence
    sequence out_win_s;
        xd_req.valid && (xd_req.addr > XREG_LAST_ADDR);
    endsequence

    a_reset_hold: assert property (reset_pin [*3] |=> core_reset)
        else $error("core reset low while reset pin high");
    a_reset_free: assert property ((!reset_pin) [*3] |=> !core_reset)
        else $error("core reset high while reset pin low");
    a_scan_map: assert property ((!core_reset) [*2] |=> ks_o == $past({p2_latch, p1_latch}))
        else $error("key scan level not from latch");
    a_latch_read: assert property ((!core_reset) [*2] |=> p1_read == $past(p1_latch))
        else $error("port read not latch");
    a_low_sink: assert property (!mouse_line_clock.o |-> mouse_line_clock.oe && !mouse_line_clock.weak_hi)
        else $error("low level not sunk");
    a_strong_span: assert property (mouse_line_clock.o && mouse_line_clock.oe |-> hi_cnt_reg < STRONG_N)
        else $error("strong high too long");
    a_strong_min: assert property (mouse_line_clock.o && mouse_line_clock.oe && hi_cnt_reg < STRONG_N - 1
        |=> mouse_line_clock.oe)
        else $error("strong high too short");
    a_xd_route: assert property (xd_req.valid && xd_req.addr <= XREG_LAST_ADDR |=>
        extension_regs.re != $past(xd_req.write) && extension_regs.we == $past(xd_req.write)
        && extension_regs.addr == $past(xd_req.addr[5:0]))
        else $error("window access not routed");
    a_xd_refuse: assert property (out_win_s |=> !extension_regs.re && !extension_regs.we)
        else $error("access outside window routed");
    a_xd_read: assert property (xd_rd_s |-> ##2 xd_rvalid)
        else $error("read answer late");
    a_xd_zero: assert property ((out_win_s and xd_rd_s) |-> ##2 xd_rdata == READ_ZERO)
        else $error("outside read not zero");
    a_sfr_direct: assert property (idata_req.valid && !idata_req.indirect && idata_req.addr >= SFR_FIRST
        |=> special_func_regs.re != $past(idata_req.write)
        && special_func_regs.addr == $past(idata_req.addr))
        else $error("direct upper access missed register block");
    a_ram_only: assert property (idata_req.valid && (idata_req.indirect || idata_req.addr <= IRAM_DIRECT_LAST)
        |=> !special_func_regs.re && !special_func_regs.we)
        else $error("RAM access reached register block");
    a_idata_read: assert property (idata_req.valid && !idata_req.write |-> ##2 idata_rvalid)
        else $error("internal read answer late");
    a_irq_route: assert property (1'b1 |=> {ext_irq_b, ext_irq_a} == $past(special_irq_src))
        else $error("interrupt not from internal source");
    a_strap_fixed: assert property (core_strap == STRAP_RESET)
        else $error("core function enabled");
endmodule

// ---- test/serial_peers.sv ----
/*
  Mouse and keyboard peers on the four serial lines.
  Assumes pseudo open-drain pins with a keeper high; peers only pull low.
*/
`timescale 1ns/1ps

module serial_peers
    import port_map_pkg::*;
(
    input  wire pin_drive_t       ms_data,
    input  wire pin_drive_t       ms_clk,
    input  wire pin_drive_t       kb_clk,
    input  wire pin_drive_t       kb_data,
    input  wire logic [3:0]       pull_low,
    output logic      [3:0]       level
);
    // A line is low when either side sinks it, else the keeper holds it high
    assign level[0] = !((ms_data.oe && !ms_data.o) || pull_low[0]);
    assign level[1] = !((ms_clk.oe && !ms_clk.o) || pull_low[1]);
    assign level[2] = !((kb_clk.oe && !kb_clk.o) || pull_low[2]);
    assign level[3] = !((kb_data.oe && !kb_data.o) || pull_low[3]);
endmodule

// ---- test/mcu_port_and_memory_map_test.sv ----
/*
  Self-checking bench for the port and memory map adapter.
  Assumes the checker and serial peer files are compiled first.
*/
`timescale 1ns/1ps

module mcu_port_and_memory_map_test
    import port_map_pkg::*;
;
    typedef struct packed {
        logic        ext;
        logic        wr;
        logic        ind;
        logic [15:0] addr;
        logic [7:0]  wd;
        logic [7:0]  exp;
    } op_t;
    localparam int XP       = 10000;
    localparam int STRONG_N = (2 * XP + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    logic clk, rst_n, reset_pin, core_reset, xd_rvalid, idata_rvalid, ext_irq_a, ext_irq_b;
    logic [7:0] p1_latch, p2_latch, p3_latch, p1_read, p2_read, p3_read, xd_rdata, idata_rdata;
    logic [1:0] special_irq_src;
    logic [3:0] pull_low, lvl;
    logic [15:0] ks_o;
    core_strap_t core_strap;
    pin_drive_t [KEY_SCAN_W-1:0] key_scan_out;
    pin_drive_t ms_d, ms_c, kb_c, kb_d;
    xd_req_t xd_req;
    xreg_req_t extension_regs;
    idata_req_t idata_req;
    sfr_req_t special_func_regs;
    int mismatches, n_compared, n;
    logic [15:0] pats [5] = '{16'h00ff, 16'ha55a, 16'hff00, 16'h0001, 16'h8000};
    op_t ops [14] = '{
        '{1'b1, 1'b0, 1'b0, 16'h0000, 8'h00, 8'h40}, '{1'b1, 1'b0, 1'b0, 16'h002f, 8'h00, 8'h6f},
        '{1'b1, 1'b0, 1'b0, 16'h0030, 8'h00, 8'h00}, '{1'b1, 1'b0, 1'b0, 16'h1000, 8'h00, 8'h00},
        '{1'b1, 1'b1, 1'b0, 16'h0010, 8'h11, 8'h00}, '{1'b1, 1'b1, 1'b0, 16'h0030, 8'h22, 8'h00},
        '{1'b0, 1'b1, 1'b1, 16'h0090, 8'h5a, 8'h00}, '{1'b0, 1'b1, 1'b0, 16'h0010, 8'ha5, 8'h00},
        '{1'b0, 1'b1, 1'b0, 16'h0090, 8'h77, 8'h00}, '{1'b0, 1'b0, 1'b1, 16'h0090, 8'h00, 8'h5a},
        '{1'b0, 1'b0, 1'b1, 16'h0010, 8'h00, 8'ha5}, '{1'b0, 1'b0, 1'b0, 16'h0090, 8'h00, 8'h6f},
        '{1'b0, 1'b1, 1'b1, 16'h00ff, 8'h3c, 8'h00}, '{1'b0, 1'b0, 1'b1, 16'h00ff, 8'h00, 8'h3c}};

    wire [7:0] xreg_rdata = {2'b01, extension_regs.addr};
    wire [7:0] sfr_rdata  = ~special_func_regs.addr;

    always_comb begin
        for (int i = 0; i < KEY_SCAN_W; i++) begin
            ks_o[i] = key_scan_out[i].o;
        end
    end

    always #2.5 clk = ~clk;

    mcu_port_and_memory_map #(.XTAL_PERIOD_PS(XP)) uut (
        .clk(clk), .rst_n(rst_n), .reset_pin(reset_pin), .core_reset(core_reset),
        .core_strap(core_strap), .p1_latch(p1_latch), .p2_latch(p2_latch), .p3_latch(p3_latch),
        .p1_read(p1_read), .p2_read(p2_read), .p3_read(p3_read), .key_scan_out(key_scan_out),
        .mouse_line_data_in(lvl[0]), .mouse_line_data(ms_d), .mouse_line_clock_in(lvl[1]),
        .mouse_line_clock(ms_c), .kbd_line_clock_in(lvl[2]), .kbd_line_clock(kb_c),
        .kbd_line_data_in(lvl[3]), .kbd_line_data(kb_d), .special_irq_src(special_irq_src),
        .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b), .xd_req(xd_req), .xd_rvalid(xd_rvalid),
        .xd_rdata(xd_rdata), .extension_regs(extension_regs), .xreg_rdata(xreg_rdata),
        .idata_req(idata_req), .idata_rvalid(idata_rvalid), .idata_rdata(idata_rdata),
        .special_func_regs(special_func_regs), .sfr_rdata(sfr_rdata));

    serial_peers peers (.ms_data(ms_d), .ms_clk(ms_c), .kb_clk(kb_c), .kb_data(kb_d),
        .pull_low(pull_low), .level(lvl));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic run_op(input op_t op);
        logic hit;
        logic [1:0] rw;
        @(negedge clk);
        if (op.ext) xd_req = '{1'b1, op.wr, op.addr, op.wd};
        else idata_req = '{1'b1, op.wr, op.ind, op.addr[7:0], op.wd};
        @(negedge clk);
        xd_req = '0;
        idata_req = '0;
        hit = op.ext ? (op.addr <= XREG_LAST_ADDR) : (!op.ind && op.addr[7:0] >= SFR_FIRST);
        rw = hit ? {!op.wr, op.wr} : 2'b00;
        if (op.ext) check(extension_regs, {rw, op.addr[5:0], op.wd});
        else check({special_func_regs.re, special_func_regs.we}, rw);
        if (!op.ext) check(special_func_regs.wdata, op.wd);
        @(negedge clk);
        if (!op.wr) check(op.ext ? {xd_rvalid, xd_rdata} : {idata_rvalid, idata_rdata}, {1'b1, op.exp});
    endtask

    task automatic give_verdict;
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        {clk, rst_n, reset_pin, special_irq_src, pull_low} = {3'b001, 2'b00, 4'h0};
        {p1_latch, p2_latch, p3_latch} = {3{8'hff}};
        xd_req = '0;
        idata_req = '0;
        repeat (6) @(negedge clk);
        check(core_reset, 1'b1);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        check(core_reset, 1'b1);
        reset_pin = 1'b0;
        repeat (4) @(negedge clk);
        check(core_reset, 1'b0);
        check(core_strap, STRAP_RESET);
        foreach (pats[k]) begin
            {p2_latch, p1_latch} = pats[k];
            repeat (3) @(negedge clk);
            check(ks_o, pats[k]);
            check({p2_read, p1_read}, pats[k]);
        end
        check(key_scan_out[15], 3'b111);
        check(key_scan_out[0], 3'b010);
        p1_latch = 8'h01;
        n = 0;
        for (int j = 0; j < 20 && !(key_scan_out[0].o && !key_scan_out[0].oe); j++) begin
            @(negedge clk);
            if (key_scan_out[0].o && key_scan_out[0].oe) n++;
        end
        check(key_scan_out[0], 3'b101);
        check(n, STRONG_N);
        foreach (ops[k]) run_op(ops[k]);
        for (int v = 0; v < 4; v++) begin
            special_irq_src = v[1:0];
            repeat (2) @(negedge clk);
            check({ext_irq_b, ext_irq_a}, v[1:0]);
        end
        p3_latch = 8'hfd;
        @(negedge clk);
        p3_latch = 8'hff;
        for (int j = 0; j < 4; j++) begin
            pull_low = 4'h1 << j;
            repeat (5) @(negedge clk);
            check(p3_read, 8'hff & ~({8'h20, 8'h10, 8'h02, 8'h01} >> (8 * j) & 8'hff));
        end
        pull_low = 4'h0;
        p3_latch = 8'h5e;
        repeat (6) @(negedge clk);
        check(p3_read, 8'h5e);
        check({ms_d, kb_d}, 6'b010_010);
        rst_n = 1'b0;
        @(negedge clk);
        check({core_reset, p1_read}, 9'h1ff);
        rst_n = 1'b1;
        repeat (5) @(negedge clk);
        check(core_reset, 1'b0);
        give_verdict();
    end
endmodule

bind mcu_port_and_memory_map port_map_asserts #(.XTAL_PERIOD_PS(XTAL_PERIOD_PS)) chk (
    .clk(clk), .rst_n(rst_n), .reset_pin(reset_pin), .core_reset(core_reset),
    .core_strap(core_strap), .p1_latch(p1_latch), .p2_latch(p2_latch), .p1_read(p1_read),
    .key_scan_out(key_scan_out), .mouse_line_clock(mouse_line_clock),
    .special_irq_src(special_irq_src), .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b),
    .xd_req(xd_req), .xd_rvalid(xd_rvalid), .xd_rdata(xd_rdata),
    .extension_regs(extension_regs), .idata_req(idata_req), .idata_rvalid(idata_rvalid),
    .special_func_regs(special_func_regs));
